// ==== design/acr_pkg.sv ====
// Package: register map, field positions, reset values and carriers for the converter control
package acr_pkg;

	// Register byte addresses (word aligned)
	localparam logic [7:0] CTRL0_ADDR     = 8'h00;
	localparam logic [7:0] CTRL1_ADDR     = 8'h04;
	localparam logic [7:0] PINEN_ADDR     = 8'h08;
	localparam logic [7:0] RESHIGH_ADDR   = 8'h0c;
	localparam logic [7:0] RESLOW_ADDR    = 8'h10;

	// Control zero field positions
	localparam int START_BIT  = 7;
	localparam int BUSY_BIT   = 6;
	localparam int PDOWN_BIT  = 5;
	localparam int ALIGN_BIT  = 4;
	localparam int CSEL1_BIT  = 1;
	localparam int CSEL0_BIT  = 0;
	// Control one field position
	localparam int CSELH_BIT  = 7;

	// Reset values
	localparam logic       START_RST  = 1'b0;
	localparam logic       BUSY_RST   = 1'b1;
	localparam logic       PDOWN_RST  = 1'b1;
	localparam logic       ALIGN_RST  = 1'b0;
	localparam logic [1:0] CSEL_RST   = 2'h0;
	localparam logic       CSELH_RST  = 1'b0;
	localparam logic [3:0] PINEN_RST  = 4'h0;
	localparam logic [11:0] RESULT_RST = 12'h000;

	// Conversion time of the modelled core in clock cycles
	localparam logic [5:0] CONV_CYCLES = 6'h10;

	// AXI4-Lite response codes
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// Register fields that steer the converter
	typedef struct packed {
		logic       powerDown;
		logic       alignRight;
		logic       channelHigh;
		logic [1:0] channelLow;
		logic [3:0] pinEnable;
	} acr_ctrl_s;

	// Converter core sequencing states
	typedef enum logic [1:0] {
		ACR_IDLE,
		ACR_RESET,
		ACR_CONVERT
	} acr_state_e;

endpackage : acr_pkg

// ==== design/acr_conv_seq.sv ====
// Conversion sequencer: start handshake, busy flag, result capture
`timescale 1ns/100ps
module acr_conv_seq (
	input  wire logic          clock,
	input  wire logic          rstn,
	input  wire logic          startBit,
	input  wire logic          powerDown,
	input  wire logic [11:0]   coreResult,
	output logic               busy,
	output logic               coreReset,
	output logic               coreSample,
	output logic [11:0]        result
);

	acr_pkg::acr_state_e state;
	logic                startPrev;
	logic [5:0]          count;

	// Start bit history for edge detection
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			startPrev <= acr_pkg::START_RST;
		end else begin
			startPrev <= startBit;
		end
	end

	// Sequence: rising start resets, falling start converts
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			state      <= acr_pkg::ACR_IDLE;
			busy       <= acr_pkg::BUSY_RST;
			coreReset  <= 1'b0;
			coreSample <= 1'b0;
			count      <= 6'h00;
			result     <= acr_pkg::RESULT_RST;
		end else begin
			coreReset  <= 1'b0;
			coreSample <= 1'b0;
			if (startBit && !startPrev) begin
				state     <= acr_pkg::ACR_RESET; // RULE1
				busy      <= 1'b1; // RULE1
				coreReset <= 1'b1; // RULE1
			end else begin
				case (state)
					acr_pkg::ACR_IDLE: begin
						state <= acr_pkg::ACR_IDLE;
					end
					acr_pkg::ACR_RESET: begin
						// Conversion begins only once start is cleared again
						if (!startBit && !powerDown) begin // RULE2 RULE4
							state      <= acr_pkg::ACR_CONVERT;
							coreSample <= 1'b1;
							count      <= acr_pkg::CONV_CYCLES;
						end
					end
					acr_pkg::ACR_CONVERT: begin
						if (powerDown) begin
							state <= acr_pkg::ACR_RESET; // RULE4
						end else if (count == 6'h01) begin
							result <= coreResult; // RULE17
							busy   <= 1'b0; // RULE3 RULE17
							state  <= acr_pkg::ACR_IDLE;
						end else begin
							count <= count - 6'h01;
						end
					end
					default: begin
						state <= acr_pkg::ACR_IDLE;
					end
				endcase
			end
		end
	end

endmodule : acr_conv_seq

// ==== design/acr_control.sv ====
// Converter control register block with AXI4-Lite slave and analog routing outputs
//
// The implementer's own choices: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/100ps

// Functional notes
// (RULE1) Start rising edge resets converter, sets busy
// (RULE2) Conversion starts when start falls again
// (RULE3) Busy flag reads high while converting only; here also high from reset and from the start rising edge
// (RULE4) Power-down bit switches converter off
// (RULE5) Software should power down before sleep
// (RULE6) Left alignment: MSB high bit7, LSB low bit4
// (RULE7) Right alignment: MSB high bit3, LSB low bit0
// (RULE8) Result is twelve bits over two bytes
// (RULE9) Unused data bits read zero
// (RULE10) Control zero bits 3..2 read zero
// (RULE11) Low select codes pick inputs 0..3
// (RULE12) Three select bits choose pin or reference
// (RULE13) High select bit routes internal reference
// (RULE14) Pin enable gives pin to converter
// (RULE15) Cleared enable keeps digital pin function
// (RULE16) Analog pins lose their pull-high
// (RULE17) Result loaded before busy clears
module acr_control (
	input  wire logic          clock,
	input  wire logic          rstn,
	// AXI4-Lite write address
	input  wire logic [7:0]    s_axi_awaddr,
	input  wire logic          s_axi_awvalid,
	output logic               s_axi_awready,
	// AXI4-Lite write data
	input  wire logic [31:0]   s_axi_wdata,
	input  wire logic [3:0]    s_axi_wstrb,
	input  wire logic          s_axi_wvalid,
	output logic               s_axi_wready,
	// AXI4-Lite write response
	output logic [1:0]         s_axi_bresp,
	output logic               s_axi_bvalid,
	input  wire logic          s_axi_bready,
	// AXI4-Lite read address
	input  wire logic [7:0]    s_axi_araddr,
	input  wire logic          s_axi_arvalid,
	output logic               s_axi_arready,
	// AXI4-Lite read data
	output logic [31:0]        s_axi_rdata,
	output logic [1:0]         s_axi_rresp,
	output logic               s_axi_rvalid,
	input  wire logic          s_axi_rready,
	// Analog core side
	input  wire logic [11:0]   coreResult,
	output logic               corePowerDown,
	output logic               coreReset,
	output logic               coreSample,
	output logic [3:0]         analogInputSelect,
	output logic               referenceSelect,
	output logic [3:0]         analogPinEnable,
	output logic [3:0]         pullHighDisable
);

	acr_pkg::acr_ctrl_s ctrl;
	logic               startBit;
	logic               busy;
	logic [11:0]        result;
	logic               seqReset;
	logic               seqSample;
	logic               awHeld;
	logic [7:0]         awAddr;
	logic               wHeld;
	logic [31:0]        wData;
	logic [3:0]         wStrb;
	logic               doWrite;
	logic               writeHit;
	logic [7:0]         resultHigh;
	logic [7:0]         resultLow;
	logic [7:0]         readByte;
	logic               readHit;
	logic [3:0]         next_analogInputSelect;

	// Conversion sequencing and result capture
	acr_conv_seq u_seq (
		.clock      (clock),
		.rstn       (rstn),
		.startBit   (startBit),
		.powerDown  (ctrl.powerDown),
		.coreResult (coreResult),
		.busy       (busy),
		.coreReset  (seqReset),
		.coreSample (seqSample),
		.result     (result)
	);

	// Write address channel: accept once, hold until response
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			awHeld <= 1'b0;
			awAddr <= 8'h00;
		end else if (s_axi_awvalid && s_axi_awready) begin
			awHeld <= 1'b1;
			awAddr <= s_axi_awaddr;
		end else if (doWrite) begin
			awHeld <= 1'b0;
		end
	end

	// Write data channel: accept once, hold until response
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			wHeld <= 1'b0;
			wData <= 32'h0000_0000;
			wStrb <= 4'h0;
		end else if (s_axi_wvalid && s_axi_wready) begin
			wHeld <= 1'b1;
			wData <= s_axi_wdata;
			wStrb <= s_axi_wstrb;
		end else if (doWrite) begin
			wHeld <= 1'b0;
		end
	end

	// Address ready is registered, low while an address is held or answered
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			s_axi_awready <= 1'b0;
		end else begin
			s_axi_awready <= !awHeld && !(s_axi_awvalid && s_axi_awready)
				&& !s_axi_bvalid;
		end
	end

	// Data ready follows the same rule for the data channel
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			s_axi_wready <= 1'b0;
		end else begin
			s_axi_wready <= !wHeld && !(s_axi_wvalid && s_axi_wready)
				&& !s_axi_bvalid;
		end
	end

	// Write commits once both halves are held and no answer is pending
	assign doWrite = awHeld && wHeld && !s_axi_bvalid;

	// Write address decode; unmapped offsets answer with an error
	always_comb begin
		writeHit = 1'b0;
		case (awAddr)
			acr_pkg::CTRL0_ADDR, acr_pkg::CTRL1_ADDR, acr_pkg::PINEN_ADDR: begin
				writeHit = 1'b1;
			end
			acr_pkg::RESHIGH_ADDR, acr_pkg::RESLOW_ADDR: begin
				writeHit = 1'b1; // Read-only: accepted, then dropped
			end
			default: begin
				writeHit = 1'b0;
			end
		endcase
	end

	// Write response
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= acr_pkg::RESP_OKAY;
		end else if (doWrite) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp  <= writeHit ? acr_pkg::RESP_OKAY : acr_pkg::RESP_SLVERR;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// Writable control fields; busy flag and result bytes ignore writes
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			startBit          <= acr_pkg::START_RST;
			ctrl.powerDown    <= acr_pkg::PDOWN_RST;
			ctrl.alignRight   <= acr_pkg::ALIGN_RST;
			ctrl.channelLow   <= acr_pkg::CSEL_RST;
			ctrl.channelHigh  <= acr_pkg::CSELH_RST;
			ctrl.pinEnable    <= acr_pkg::PINEN_RST;
		end else if (doWrite && wStrb[0]) begin
			case (awAddr)
				acr_pkg::CTRL0_ADDR: begin
					startBit        <= wData[acr_pkg::START_BIT]; // RULE1 RULE2
					ctrl.powerDown  <= wData[acr_pkg::PDOWN_BIT]; // RULE4
					ctrl.alignRight <= wData[acr_pkg::ALIGN_BIT];
					ctrl.channelLow <= wData[acr_pkg::CSEL1_BIT:acr_pkg::CSEL0_BIT];
				end
				acr_pkg::CTRL1_ADDR: begin
					ctrl.channelHigh <= wData[acr_pkg::CSELH_BIT];
				end
				acr_pkg::PINEN_ADDR: begin
					ctrl.pinEnable <= wData[3:0];
				end
				default: begin
					ctrl.pinEnable <= ctrl.pinEnable;
				end
			endcase
		end
	end

	// Result byte layout by alignment
	always_comb begin
		if (ctrl.alignRight) begin
			resultHigh = {4'h0, result[11:8]}; // RULE7 RULE9
			resultLow  = result[7:0]; // RULE7
		end else begin
			resultHigh = result[11:4]; // RULE6 RULE8
			resultLow  = {result[3:0], 4'h0}; // RULE6 RULE9
		end
	end

	// Read decode; unimplemented bits return zero
	always_comb begin
		readHit  = 1'b1;
		readByte = 8'h00;
		case (s_axi_araddr)
			acr_pkg::CTRL0_ADDR: begin
				readByte = {startBit, busy, ctrl.powerDown, ctrl.alignRight,
					2'h0, ctrl.channelLow}; // RULE3 RULE10
			end
			acr_pkg::CTRL1_ADDR: begin
				readByte = {ctrl.channelHigh, 7'h00};
			end
			acr_pkg::PINEN_ADDR: begin
				readByte = {4'h0, ctrl.pinEnable};
			end
			acr_pkg::RESHIGH_ADDR: begin
				readByte = resultHigh; // RULE8
			end
			acr_pkg::RESLOW_ADDR: begin
				readByte = resultLow; // RULE8
			end
			default: begin
				readHit = 1'b0;
			end
		endcase
	end

	// Read channel: take address, answer next cycle, hold until rready
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0000_0000;
			s_axi_rresp   <= acr_pkg::RESP_OKAY;
		end else begin
			s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata  <= {24'h000000, readByte};
				s_axi_rresp  <= readHit ? acr_pkg::RESP_OKAY : acr_pkg::RESP_SLVERR;
			end else if (s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

	// Converter power and sequencing pulses, registered for clean outputs
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			corePowerDown <= acr_pkg::PDOWN_RST;
			coreReset     <= 1'b0;
			coreSample    <= 1'b0;
		end else begin
			corePowerDown <= ctrl.powerDown; // RULE4
			coreReset     <= seqReset; // RULE1
			coreSample    <= seqSample; // RULE2
		end
	end

	// Input pin decode: one-hot, nothing while the reference is routed
	always_comb begin
		next_analogInputSelect = 4'h0;
		if (ctrl.channelHigh) begin
			next_analogInputSelect = 4'h0; // RULE13
		end else begin
			case (ctrl.channelLow)
				2'h0: begin
					next_analogInputSelect = 4'h1; // RULE11
				end
				2'h1: begin
					next_analogInputSelect = 4'h2; // RULE11
				end
				2'h2: begin
					next_analogInputSelect = 4'h4; // RULE11
				end
				2'h3: begin
					next_analogInputSelect = 4'h8; // RULE11
				end
				default: begin
					next_analogInputSelect = 4'h0;
				end
			endcase
		end
	end

	// Analog routing and pin hand-over, registered for clean outputs
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			analogInputSelect <= 4'h0;
			referenceSelect   <= 1'b0;
			analogPinEnable   <= 4'h0;
			pullHighDisable   <= 4'h0;
		end else begin
			referenceSelect   <= ctrl.channelHigh; // RULE12 RULE13
			analogInputSelect <= next_analogInputSelect; // RULE11 RULE12
			analogPinEnable   <= ctrl.pinEnable; // RULE14 RULE15
			pullHighDisable   <= ctrl.pinEnable; // RULE16
		end
	end

endmodule : acr_control

// ==== bench/acr_control_properties.sv ====
// Checker: bus handshakes and converter control outputs
`timescale 1ns/100ps
module acr_control_properties (
	input wire logic        clock,
	input wire logic        rstn,
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_awready,
	input wire logic        s_axi_wvalid,
	input wire logic        s_axi_wready,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	input wire logic        corePowerDown,
	input wire logic        coreReset,
	input wire logic        coreSample,
	input wire logic [3:0]  analogInputSelect,
	input wire logic        referenceSelect,
	input wire logic [3:0]  analogPinEnable,
	input wire logic [3:0]  pullHighDisable
);
	default clocking @(posedge clock); endclocking
	default disable iff (!rstn);
	// Request steps on the bus
	sequence sBothTaken;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	sequence sReadTaken;
		s_axi_arvalid && s_axi_arready;
	endsequence
	a_write_answer: assert property (sBothTaken |-> ##2 s_axi_bvalid)
		else $error("write response late");
	a_read_answer: assert property (sReadTaken |=> s_axi_rvalid)
		else $error("read data late");
	a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
		else $error("write response dropped");
	a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> $stable(s_axi_rdata))
		else $error("read data changed");
	a_upper_zero: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
		else $error("upper read bits set");
	a_pull_follow: assert property (pullHighDisable == analogPinEnable)
		else $error("pull-high not removed");
	a_ref_exclusive: assert property (referenceSelect |-> analogInputSelect == 4'h0)
		else $error("pin routed with reference");
	a_route_onehot: assert property ($onehot0(analogInputSelect))
		else $error("two pins routed");
	a_sample_powered: assert property (coreSample |-> !corePowerDown)
		else $error("sample while off");
	a_sample_pulse: assert property (coreSample |=> !coreSample [*4])
		else $error("sample repeated");
	a_reset_pulse: assert property (coreReset |=> !coreReset)
		else $error("core reset too long");
endmodule : acr_control_properties

bind acr_control acr_control_properties acr_control_properties_inst (.*);

// ==== bench/acr_core_model.sv ====
// Analog core model: fixed input values, drifting output while off
`timescale 1ns/100ps
module acr_core_model (
	input  wire logic        clock,
	input  wire logic        corePowerDown,
	input  wire logic        referenceSelect,
	input  wire logic [3:0]  analogInputSelect,
	output logic [11:0]      coreResult
);
	logic [11:0] drift = 12'h000;
	// Changes every cycle so a stale sample never looks right
	always @(posedge clock) drift <= drift + 12'h3c7;
	// Routed source feeds the shared converter
	always_comb begin
		coreResult = drift;
		if (corePowerDown) coreResult = drift;
		else if (referenceSelect) coreResult = 12'h7e1;
		else case (analogInputSelect)
			4'h1: coreResult = 12'h9d2;
			4'h2: coreResult = 12'h4a7;
			4'h4: coreResult = 12'hc3e;
			4'h8: coreResult = 12'h15b;
			default: coreResult = drift;
		endcase
	end
endmodule : acr_core_model

// ==== bench/testbench.sv ====
// Testbench: register access, conversions, routing and pin handover
`timescale 1ns/100ps
module testbench;
	logic        clock, rstn;
	logic [7:0]  s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [3:0]  s_axi_wstrb;
	logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
	logic        s_axi_rvalid, s_axi_rready;
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	logic [11:0] coreResult;
	logic        corePowerDown, coreReset, coreSample, referenceSelect;
	logic [3:0]  analogInputSelect, analogPinEnable, pullHighDisable;
	int          mismatches, compares, resets, samples;
	logic [11:0] vals [5] = '{12'h9d2, 12'h4a7, 12'hc3e, 12'h15b, 12'h7e1};

	acr_control acr_control_inst (.*);
	acr_core_model acr_core_model_inst (.*);

	// Free-running clock
	initial begin
		clock = 0;
		forever #2.5 clock = ~clock;
	end

	// Counts converter reset pulses
	always @(posedge clock) if (coreReset === 1'b1) resets++;
	// Counts conversion start pulses
	always @(posedge clock) if (coreSample === 1'b1) samples++;

	task automatic chk(input string n, input logic [31:0] e, s);
		compares++;
		if (s !== e) begin
			$display("unexpected %s expected %h seen %h", n, e, s);
			mismatches++;
		end
	endtask : chk

	task automatic wc(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		logic pa, pw;
		pa = 1;
		pw = 1;
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1;
		s_axi_wvalid <= 1;
		s_axi_bready <= 1;
		while (pa | pw) begin
			@(posedge clock);
			if (pa && s_axi_awready) begin
				pa = 0;
				s_axi_awvalid <= 0;
			end
			if (pw && s_axi_wready) begin
				pw = 0;
				s_axi_wvalid <= 0;
			end
		end
		do @(posedge clock); while (!s_axi_bvalid);
		chk("bresp", er, s_axi_bresp);
		s_axi_bready <= 0;
		@(posedge clock);
	endtask : wc

	task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1;
		s_axi_rready <= 1;
		do @(posedge clock); while (!s_axi_arready);
		s_axi_arvalid <= 0;
		do @(posedge clock); while (!s_axi_rvalid);
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 0;
		@(posedge clock);
	endtask : rd

	task automatic rc(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
		logic [31:0] d;
		logic [1:0]  r;
		rd(a, d, r);
		chk($sformatf("rdata %h", a), e, d);
		chk("rresp", er, r);
	endtask : rc

	task automatic conv(input logic [7:0] c, input logic [11:0] x);
		logic [31:0] d;
		logic [1:0]  r;
		int          n0, n, s0;
		n0 = resets;
		s0 = samples;
		n = 0;
		wc(acr_pkg::CTRL0_ADDR, {24'h0, c | 8'h80}, acr_pkg::RESP_OKAY);
		rc(acr_pkg::CTRL0_ADDR, {24'h0, c | 8'hc0}, acr_pkg::RESP_OKAY);
		chk("core resets", n0 + 1, resets);
		chk("early samples", s0, samples);
		wc(acr_pkg::CTRL0_ADDR, {24'h0, c}, acr_pkg::RESP_OKAY);
		do begin
			rd(acr_pkg::CTRL0_ADDR, d, r);
			n++;
		end while (d[6] && n < 20);
		chk("busy clear", {24'h0, c}, d);
		chk("core samples", s0 + 1, samples);
		rc(acr_pkg::RESHIGH_ADDR, {24'h0, c[4] ? {4'h0, x[11:8]} : x[11:4]}, 2'h0);
		rc(acr_pkg::RESLOW_ADDR, {24'h0, c[4] ? x[7:0] : {x[3:0], 4'h0}}, 2'h0);
	endtask : conv

	task automatic t_reset;
		rc(acr_pkg::CTRL0_ADDR, 32'h60, acr_pkg::RESP_OKAY);
		rc(acr_pkg::CTRL1_ADDR, 32'h0, acr_pkg::RESP_OKAY);
		rc(acr_pkg::PINEN_ADDR, 32'h0, acr_pkg::RESP_OKAY);
		rc(acr_pkg::RESHIGH_ADDR, 32'h0, acr_pkg::RESP_OKAY);
		chk("power down", 1, corePowerDown);
	endtask : t_reset

	task automatic t_routes;
		for (int k = 0; k < 5; k++) begin
			wc(acr_pkg::CTRL1_ADDR, (k == 4) ? 32'h80 : 32'h0, acr_pkg::RESP_OKAY);
			conv({3'h0, k[0], 2'h0, (k == 4) ? 2'h3 : k[1:0]}, vals[k]);
			chk("power down", 0, corePowerDown);
			chk("pin route", (k == 4) ? 4'h0 : 4'h1 << k, analogInputSelect);
			chk("ref route", k == 4, referenceSelect);
		end
		wc(acr_pkg::CTRL0_ADDR, 32'h20, acr_pkg::RESP_OKAY);
		chk("power down", 1, corePowerDown);
	endtask : t_routes

	task automatic t_pins;
		for (int p = 5; p < 16; p += 5) begin
			wc(acr_pkg::PINEN_ADDR, p, acr_pkg::RESP_OKAY);
			rc(acr_pkg::PINEN_ADDR, p, acr_pkg::RESP_OKAY);
			chk("pin enable", p, analogPinEnable);
			chk("pull removed", p, pullHighDisable);
		end
	endtask : t_pins

	task automatic t_refuse;
		wc(acr_pkg::CTRL0_ADDR, 32'h4c, acr_pkg::RESP_OKAY);
		rc(acr_pkg::CTRL0_ADDR, 32'h0, acr_pkg::RESP_OKAY);
		wc(acr_pkg::RESHIGH_ADDR, 32'hff, acr_pkg::RESP_OKAY);
		rc(acr_pkg::RESHIGH_ADDR, 32'h7e, acr_pkg::RESP_OKAY);
		wc(8'h14, 32'hff, acr_pkg::RESP_SLVERR);
		rc(8'h14, 32'h0, acr_pkg::RESP_SLVERR);
		s_axi_wstrb <= 4'he;
		wc(acr_pkg::CTRL1_ADDR, 32'h0, acr_pkg::RESP_OKAY);
		s_axi_wstrb <= 4'hf;
		rc(acr_pkg::CTRL1_ADDR, 32'h80, acr_pkg::RESP_OKAY);
	endtask : t_refuse

	task automatic results;
		$display("mismatches %0d compares %0d", mismatches, compares);
		if (mismatches == 0 && compares > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : results

	// Reset, then the scenarios in order
	initial begin
		rstn = 0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
		s_axi_wstrb = 4'hf;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		repeat (4) @(posedge clock);
		rstn <= 1;
		@(posedge clock);
		t_reset;
		t_routes;
		t_pins;
		t_refuse;
		results;
	end

	// Watchdog against a hung handshake
	initial begin
		#200000;
		mismatches++;
		results;
	end
endmodule : testbench
